// >>> core/awc_axis.sv
// One axis of the watch logic: delta, threshold compare and detection count.
`timescale 1ns/1ps
module awc_axis
   import awc_pkg::*;
(
   // Clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   // Sample stream
   input  wire logic signed [AWC_SW-1:0]  sample_i,
   input  wire logic                      sample_valid_i,
   // Configuration
   input  wire logic                      active_i,
   input  wire logic                      ref_base_i,
   input  wire logic [5:0]                limit_i,
   input  wire logic [5:0]                count_i,
   // Result
   output logic                           met_o
);

   typedef struct packed {
      logic signed [AWC_SW-1:0] prev;
      logic signed [AWC_SW-1:0] base;
      logic                     have_prev;
      logic                     have_base;
      logic [5:0]               hits;
      logic                     met;
   } awc_ax_t;

   awc_ax_t q_r;
   awc_ax_t q_nxt;
   logic signed [AWC_SW-1:0] ref_smp;
   logic signed [AWC_SW:0]   diff;
   logic [AWC_SW:0]          delta;
   logic                     have_ref;
   logic                     exceed;

   always_comb
   begin
      ref_smp  = ref_base_i ? q_r.base : q_r.prev;
      // Both sides are sign-extended first, so the difference never wraps.
      diff     = (AWC_SW+1)'(sample_i) - (AWC_SW+1)'(ref_smp);
      delta    = diff[AWC_SW] ? $unsigned(-diff) : $unsigned(diff);
      have_ref = ref_base_i ? q_r.have_base : q_r.have_prev;
      exceed   = have_ref && (delta > {{(AWC_SW-5){1'b0}}, limit_i});
   end

   always_comb
   begin
      q_nxt     = q_r;
      q_nxt.met = 1'b0;
      if (!active_i)
      begin
         q_nxt.have_prev = 1'b0;
         q_nxt.have_base = 1'b0;
         q_nxt.hits      = 6'h00;
      end
      else if (sample_valid_i)
      begin
         q_nxt.prev      = sample_i;
         q_nxt.have_prev = 1'b1;
         if (!q_r.have_base)
         begin
            q_nxt.base      = sample_i;
            q_nxt.have_base = 1'b1;
         end
         if (exceed)
         begin
            q_nxt.hits = (q_r.hits == AWC_HITS_MAX) ? q_r.hits : q_r.hits + 6'h01;
            q_nxt.met  = (q_nxt.hits > count_i);
         end
         else
         begin
            q_nxt.hits = 6'h00;
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         q_r <= '0;
      else
         q_r <= q_nxt;
   end

   assign met_o = q_r.met;

   base_capture_a: assert property (@(posedge clk_i) disable iff (rst_i)
      active_i && sample_valid_i && !q_r.have_base |=> q_r.base == $past(sample_i))
      else $error("Baseline not captured from first sample.");

   miss_clears_a: assert property (@(posedge clk_i) disable iff (rst_i)
      active_i && sample_valid_i && !exceed |=> q_r.hits == 6'h00 && !met_o)
      else $error("Hit count not cleared on a quiet sample.");

endmodule // awc_axis

// >>> core/awc_pkg.sv
// Package holding offsets, field positions, reset values and codes of the activity watch block.
package awc_pkg;

   // Sample width and bus word width.
   localparam int          AWC_SW  = 12;
   localparam int          AWC_DW  = 32;

   // Register indices; the byte address is four times the index.
   localparam logic [7:0]  AWC_IDX_RATE = 8'h12;
   localparam logic [7:0]  AWC_IDX_THR  = 8'h13;
   localparam logic [7:0]  AWC_IDX_CFG  = 8'h14;
   localparam logic [7:0]  AWC_IDX_WCTL = 8'h20;
   localparam logic [7:0]  AWC_IDX_STAT = 8'h21;
   localparam logic [7:0]  AWC_IDX_CLR  = 8'h22;
   localparam logic [7:0]  AWC_IDX_IEN  = 8'h23;

   // Field positions.
   localparam int          AWC_RATE_STB_LSB = 5;
   localparam int          AWC_RATE_RSV_BIT = 4;
   localparam int          AWC_THR_REF_BIT  = 7;
   localparam int          AWC_THR_AO_BIT   = 6;
   localparam int          AWC_WCTL_AX_LSB  = 1;
   localparam int          AWC_ST_WAKE      = 0;
   localparam int          AWC_ST_AX_LSB    = 1;

   // Values after reset, and the saturation value of the hit count.
   localparam logic [2:0]  AWC_RST_STB  = 3'h0;
   localparam logic [3:0]  AWC_RST_SMP  = 4'h0;
   localparam logic [5:0]  AWC_RST_SHD  = 6'h00;
   localparam logic [2:0]  AWC_RST_SEL  = 3'h0;
   localparam logic [2:0]  AWC_RST_AXEN = 3'h7;
   localparam logic [3:0]  AWC_RST_STAT = 4'h0;
   localparam logic [5:0]  AWC_HITS_MAX = 6'h3f;

   // Shadow selector codes.
   localparam logic [2:0]  AWC_SEL_NONE = 3'h0;
   localparam logic [2:0]  AWC_SEL_LIMX = 3'h1;
   localparam logic [2:0]  AWC_SEL_GAP  = 3'h4;
   localparam logic [2:0]  AWC_SEL_CNTX = 3'h5;

endpackage

// >>> core/awc_top.sv
// Activity watch configuration, shadow thresholds, wake decision and Wishbone slave.
// Operation
// - Bits seven to five select one of eight standby clock rates, 000 slowest.
// - Each axis delta is compared with its threshold; above means axis wake.
// - Separate axis thresholds; optional count demands several detections first.
// - Six shadow registers reached through threshold window, chosen by selector.
// - Axis wake flags combine by AND or OR into the wake event.
// - Previous mode subtracts the preceding sample.
// - Baseline mode subtracts the first sample after entering watch mode.
// - Threshold register: reference bit seven, AND/OR bit six, window five to zero.
// - Code 000 addresses nothing; 001 the X threshold, 0 to 63.
// - Codes 010 and 011 address the Y and Z thresholds.
// - Codes 101 to 111 address X, Y, Z counts, stored minus one.
// - AND/OR zero: any active axis wakes; one: all active axes.
// - Reference select zero uses previous sample, one uses baseline.
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
module awc_top
   import awc_pkg::*;
(
   // Clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   // Wishbone slave
   input  wire logic                      wb_cyc_i,
   input  wire logic                      wb_stb_i,
   input  wire logic                      wb_we_i,
   input  wire logic [9:0]                wb_adr_i,
   input  wire logic [3:0]                wb_sel_i,
   input  wire logic [AWC_DW-1:0]         wb_dat_i,
   output logic [AWC_DW-1:0]              wb_dat_o,
   output logic                           wb_ack_o,
   // Axis samples from the converter
   input  wire logic signed [AWC_SW-1:0]  x_sample_i,
   input  wire logic signed [AWC_SW-1:0]  y_sample_i,
   input  wire logic signed [AWC_SW-1:0]  z_sample_i,
   input  wire logic                      sample_valid_i,
   // Rate selections to the clock generator
   output logic [2:0]                     standby_clock_rate_o,
   output logic [3:0]                     watch_sample_rate_o,
   // Wake event and interrupt
   output logic                           wake_o,
   output logic                           irq_o
);

   typedef struct packed {
      logic              ack;
      logic [AWC_DW-1:0] dat;
      logic [2:0]        standby_clock_rate;
      logic [3:0]        smp_rate;
      logic              ref_base;
      logic              and_mode;
      logic [2:0]        sel;
      logic [2:0][5:0]   lim;
      logic [2:0][5:0]   cnt;
      logic              watch_en;
      logic [2:0]        axis_en;
      logic [3:0]        stat;
      logic [3:0]        ien;
      logic              wake;
   } awc_state_t;

   awc_state_t q_r;
   awc_state_t q_nxt;

   logic [7:0]                         idx;
   logic                               req;
   logic                               wr;
   logic [1:0]                         shd_idx;
   logic                               shd_none;
   logic [5:0]                         shd_rd;
   logic [2:0]                         met;
   logic [2:0]                         act;
   logic                               any_met;
   logic                               all_met;
   logic                               wake_ev;
   logic [2:0][AWC_SW-1:0]             smp;

   assign smp = {z_sample_i, y_sample_i, x_sample_i};

   // Bus decode; the write lands at the edge where the master sees ack.
   assign idx = wb_adr_i[9:2];
   assign req = wb_cyc_i && wb_stb_i;
   assign wr  = req && wb_we_i && q_r.ack && wb_sel_i[0];

   assign shd_idx  = q_r.sel[1:0] - 2'h1;
   assign shd_none = (q_r.sel[1:0] == 2'h0);

   always_comb
   begin
      shd_rd = 6'h00;
      if (!shd_none)
         shd_rd = q_r.sel[2] ? q_r.cnt[shd_idx] : q_r.lim[shd_idx];
   end

   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_axis
         awc_axis u_axis (
            .clk_i          (clk_i),
            .rst_i          (rst_i),
            .sample_i       (smp[g]),
            .sample_valid_i (sample_valid_i),
            .active_i       (act[g]),
            .ref_base_i     (q_r.ref_base),
            .limit_i        (q_r.lim[g]),
            .count_i        (q_r.cnt[g]),
            .met_o          (met[g])
         );
      end
   endgenerate

   assign act = q_r.axis_en & {3{q_r.watch_en}};

   always_comb
   begin
      any_met = |(met & act);
      all_met = (act != 3'h0) && ((met | ~act) == 3'h7);
      // OR by default, AND on select
      wake_ev = q_r.and_mode ? all_met : any_met;
   end

   always_comb
   begin
      q_nxt      = q_r;
      q_nxt.wake = wake_ev;
      // Ack for one cycle, then drop so a held request is not answered twice.
      q_nxt.ack  = req && !q_r.ack;
      if (req && !q_r.ack)
      begin
         q_nxt.dat = '0;
         case (idx)
            AWC_IDX_RATE:
               q_nxt.dat[7:0] = {q_r.standby_clock_rate, 1'b0, q_r.smp_rate};
            AWC_IDX_THR:
               q_nxt.dat[7:0] = {q_r.ref_base, q_r.and_mode, shd_rd};
            AWC_IDX_CFG:
               q_nxt.dat[2:0] = q_r.sel;
            AWC_IDX_WCTL:
               q_nxt.dat[3:0] = {q_r.axis_en, q_r.watch_en};
            AWC_IDX_STAT:
               q_nxt.dat[3:0] = q_r.stat;
            AWC_IDX_IEN:
               q_nxt.dat[3:0] = q_r.ien;
            default:
               q_nxt.dat = '0;
         endcase
      end
      if (wr)
      begin
         case (idx)
            AWC_IDX_RATE:
            begin
               q_nxt.standby_clock_rate = wb_dat_i[AWC_RATE_STB_LSB +: 3];
               q_nxt.smp_rate = wb_dat_i[3:0];
            end
            AWC_IDX_THR:
            begin
               q_nxt.ref_base = wb_dat_i[AWC_THR_REF_BIT];
               q_nxt.and_mode = wb_dat_i[AWC_THR_AO_BIT];
               if (!shd_none)
               begin
                  if (q_r.sel[2])
                     q_nxt.cnt[shd_idx] = wb_dat_i[5:0];
                  else
                     q_nxt.lim[shd_idx] = wb_dat_i[5:0];
               end
            end
            AWC_IDX_CFG:
               q_nxt.sel = wb_dat_i[2:0];
            AWC_IDX_WCTL:
            begin
               q_nxt.watch_en = wb_dat_i[0];
               q_nxt.axis_en  = wb_dat_i[AWC_WCTL_AX_LSB +: 3];
            end
            AWC_IDX_IEN:
               q_nxt.ien = wb_dat_i[3:0];
            default:
               q_nxt.ien = q_r.ien;
         endcase
      end
      // Events are applied after the clear so a same-cycle event survives.
      if (wr && idx == AWC_IDX_CLR)
         q_nxt.stat = q_r.stat & ~wb_dat_i[3:0];
      q_nxt.stat[AWC_ST_AX_LSB +: 3] = q_nxt.stat[AWC_ST_AX_LSB +: 3] | (met & act);
      q_nxt.stat[AWC_ST_WAKE]        = q_nxt.stat[AWC_ST_WAKE] | wake_ev;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q_r          <= '0;
         q_r.standby_clock_rate <= AWC_RST_STB;
         q_r.smp_rate <= AWC_RST_SMP;
         q_r.sel      <= AWC_RST_SEL;
         q_r.lim      <= {3{AWC_RST_SHD}};
         q_r.cnt      <= {3{AWC_RST_SHD}};
         q_r.axis_en  <= AWC_RST_AXEN;
         q_r.stat     <= AWC_RST_STAT;
      end
      else
      begin
         q_r <= q_nxt;
      end
   end

   assign wb_ack_o             = q_r.ack;
   assign wb_dat_o             = q_r.dat;
   assign standby_clock_rate_o = q_r.standby_clock_rate;
   assign watch_sample_rate_o  = q_r.smp_rate;
   assign wake_o               = q_r.wake;
   // The level stays up until software clears every enabled cause.
   assign irq_o                = |(q_r.stat & q_r.ien);

   sequence s_new_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   sequence s_answer;
      wb_ack_o ##1 !wb_ack_o;
   endsequence

   sequence s_wr_thr;
      wr && idx == AWC_IDX_THR;
   endsequence

   sequence s_rd_ack;
      wb_ack_o && !wb_we_i;
   endsequence

   sequence s_wr_clr;
      wr && idx == AWC_IDX_CLR;
   endsequence

   bus_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_new_req |=> s_answer)
      else $error("Bus answer is not a single-cycle ack one cycle after request.");

   rsv_reads_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o && !wb_we_i && idx == AWC_IDX_RATE |-> wb_dat_o[AWC_RATE_RSV_BIT] == 1'b0)
      else $error("Reserved rate bit reads nonzero.");

   standby_clock_rate_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == AWC_IDX_RATE |=> standby_clock_rate_o == $past(wb_dat_i[7:5]))
      else $error("Standby rate field not taken from write.");

   shadow_x_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_wr_thr ##0 (q_r.sel == AWC_SEL_LIMX) |=> q_r.lim[0] == $past(wb_dat_i[5:0]))
      else $error("X threshold not written through window.");

   count_x_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_wr_thr ##0 (q_r.sel == AWC_SEL_CNTX) |=> q_r.cnt[0] == $past(wb_dat_i[5:0]))
      else $error("X detection count not written through window.");

   gap_no_store_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_wr_thr ##0 (q_r.sel == AWC_SEL_GAP || q_r.sel == AWC_SEL_NONE)
      |=> $stable(q_r.lim) && $stable(q_r.cnt))
      else $error("Gap selector code changed a shadow value.");

   or_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !q_r.and_mode && (|(met & act)) |=> wake_o && q_r.stat[AWC_ST_WAKE])
      else $error("OR mode missed a wake from an active axis.");

   and_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
      q_r.and_mode && ((met | ~act) != 3'h7) |=> !wake_o)
      else $error("AND mode woke with an active axis not met.");

   sticky_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
      q_r.stat[AWC_ST_WAKE] && !(wr && idx == AWC_IDX_CLR && wb_dat_i[AWC_ST_WAKE])
      |=> q_r.stat[AWC_ST_WAKE])
      else $error("Wake status lost without a clear.");

   // Each axis slot of the window must reach its own threshold or count only.
   genvar a;
   generate
      for (a = 0; a < 3; a++)
      begin : g_axis_chk
         shadow_lim_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
            s_wr_thr ##0 (q_r.sel == AWC_SEL_LIMX + 3'(a))
            |=> q_r.lim[a] == $past(wb_dat_i[5:0]) && $stable(q_r.cnt))
            else $error("Axis threshold not written through window.");

         shadow_cnt_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
            s_wr_thr ##0 (q_r.sel == AWC_SEL_CNTX + 3'(a))
            |=> q_r.cnt[a] == $past(wb_dat_i[5:0]) && $stable(q_r.lim))
            else $error("Axis detection count not written through window.");

         shadow_rd_a: assert property (@(posedge clk_i) disable iff (rst_i)
            s_rd_ack ##0 (idx == AWC_IDX_THR && q_r.sel == AWC_SEL_LIMX + 3'(a))
            |-> wb_dat_o[5:0] == q_r.lim[a])
            else $error("Window read did not return the axis threshold.");

         axis_stat_a: assert property (@(posedge clk_i) disable iff (rst_i)
            met[a] && act[a]
            |=> q_r.stat[AWC_ST_AX_LSB + a])
            else $error("Axis status bit not set by a met axis.");
      end
   endgenerate

   mode_bits_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_wr_thr |=> q_r.ref_base == $past(wb_dat_i[AWC_THR_REF_BIT])
      && q_r.and_mode == $past(wb_dat_i[AWC_THR_AO_BIT]))
      else $error("Threshold mode bits not taken from write.");

   // A gap code still answers, so a scan over all eight codes reads zeros there.
   gap_reads_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_rd_ack ##0 (idx == AWC_IDX_THR && shd_none) |-> wb_dat_o[5:0] == 6'h00)
      else $error("Gap selector code read back a nonzero window.");

   ack_needs_req_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("Ack given without a request.");

   and_wake_a: assert property (@(posedge clk_i) disable iff (rst_i)
      q_r.and_mode && act != 3'h0 && (met | ~act) == 3'h7 |=> wake_o)
      else $error("AND mode missed a wake with every active axis met.");

   status_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
      s_wr_clr ##0 (wb_dat_i[AWC_ST_WAKE] && !wake_ev) |=> !q_r.stat[AWC_ST_WAKE])
      else $error("Wake status not cleared by a clear write.");

   // A clear in the cycle of a wake must lose, or software could miss the event.
   wake_sets_stat_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wake_o |-> q_r.stat[AWC_ST_WAKE])
      else $error("Wake pulse without its status bit.");

   smp_rate_wr_a: assert property (@(posedge clk_i) disable iff (rst_i)
      wr && idx == AWC_IDX_RATE |=> watch_sample_rate_o == $past(wb_dat_i[3:0]))
      else $error("Watch sample rate field not taken from write.");

endmodule // awc_top

// >>> testbench/awc_host.sv
// Host model: Wishbone master cycles and the fastest watch-rate setup.
`timescale 1ns/1ps
module awc_host
   import awc_pkg::*;
(
   // Clock
   input  wire logic              clk_i,
   // Wishbone master
   output logic                   cyc_o,
   output logic                   stb_o,
   output logic                   we_o,
   output logic [9:0]             adr_o,
   output logic [3:0]             sel_o,
   output logic [AWC_DW-1:0]      dat_o,
   input  wire logic [AWC_DW-1:0] dat_i,
   input  wire logic              ack_i
);
   initial
   begin
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
   end

   // The request is held until ack is seen, so a slow answer is fine.
   task automatic xfer(input logic w, input logic [7:0] i, v, output logic [AWC_DW-1:0] q);
      @(posedge clk_i);
      {cyc_o, stb_o, we_o, sel_o} <= {2'b11, w, 4'hf};
      adr_o <= {i, 2'b00};
      dat_o <= {24'h000000, v};
      @(posedge clk_i);
      while (ack_i !== 1'b1)
         @(posedge clk_i);
      q = dat_i;
      {cyc_o, stb_o, we_o} <= 3'h0;
   endtask

   task automatic fast_seq(input int m);
      logic [7:0]        md [3] = '{8'h30, 8'h00, 8'h40};
      logic [7:0]        v1 [3] = '{8'h52, 8'h72, 8'h32};
      logic [7:0]        v2 [3] = '{8'h01, 8'h02, 8'h12};
      logic [15:0]       s [14];
      logic [AWC_DW-1:0] q;
      s = '{16'h1001, 16'h1504, 16'h165d, {8'h1c, md[m]}, 16'h1110, 16'h2930, 16'h1130,
            16'h2901, 16'h1160, {8'h29, v1[m]}, 16'h1170, {8'h29, v2[m]}, 16'h110f, 16'h1002};
      foreach (s[k])
         xfer(1'b1, s[k][15:8], s[k][7:0], q);
   endtask
endmodule // awc_host

// >>> testbench/awc_top_tb_top.sv
// Self-checking bench of the activity watch block.
`timescale 1ns/1ps
module awc_top_tb_top;
   import awc_pkg::*;
   logic                     clk_i = 1'b0;
   logic                     rst_i = 1'b1;
   logic                     cyc, stb, we, ack, wake, irq, e;
   logic                     vld = 1'b0;
   logic [9:0]               adr;
   logic [3:0]               sel, smr;
   logic [2:0]               sbr;
   logic [AWC_DW-1:0]        dw, dr, q;
   logic signed [AWC_SW-1:0] sx = '0, sy = '0, sz = '0;
   logic [5:0]               sh [8];
   logic [7:0]               d;
   int                       c [3], p [3];
   int                       n_fail = 0, n_checks = 0;

   always #2.5 clk_i = ~clk_i;

   awc_host awc_host_inst (.clk_i(clk_i), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .adr_o(adr), .sel_o(sel), .dat_o(dw), .dat_i(dr), .ack_i(ack));
   awc_top awc_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
      .wb_ack_o(ack), .x_sample_i(sx), .y_sample_i(sy), .z_sample_i(sz),
      .sample_valid_i(vld), .standby_clock_rate_o(sbr), .watch_sample_rate_o(smr),
      .wake_o(wake), .irq_o(irq));

   task automatic chk_word(input logic [AWC_DW-1:0] g, x);
      n_checks++;
      if (g !== x)
      begin
         n_fail++;
         $display("[FAIL] %0t got %h expected %h", $time, g, x);
      end
   endtask

   task automatic chk_bit(input logic g, x);
      chk_word({31'h0, g}, {31'h0, x});
   endtask

   task automatic wr(input logic [7:0] i, v);
      awc_host_inst.xfer(1'b1, i, v, q);
   endtask

   task automatic rd_chk(input logic [7:0] i, x);
      awc_host_inst.xfer(1'b0, i, 8'h00, q);
      chk_word(q, {24'h000000, x});
   endtask

   task automatic shd(input logic [2:0] s, input logic [7:0] v);
      wr(AWC_IDX_CFG, {5'h00, s});
      wr(AWC_IDX_THR, v);
   endtask

   // A wake pulse is looked for over a short window, since its exact cycle may shift.
   task automatic smp(input int x, y, z, input logic xw);
      logic w = 1'b0;
      @(posedge clk_i);
      sx <= AWC_SW'(x);
      sy <= AWC_SW'(y);
      sz <= AWC_SW'(z);
      vld <= 1'b1;
      @(posedge clk_i);
      vld <= 1'b0;
      repeat (3)
      begin
         @(posedge clk_i);
         #1 w = w | wake;
      end
      chk_bit(w, xw);
   endtask

   function automatic logic over(input int a, b, t);
      return ((a > b) ? a - b : b - a) > t;
   endfunction

   task automatic give_verdict();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      #200000;
      n_fail++;
      give_verdict();
   end

   initial
   begin
      void'($urandom(19796));
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd_chk(AWC_IDX_THR, 8'h00);
      chk_bit(irq, 1'b0);
      for (int r = 0; r < 8; r++)
      begin
         d = {r[2:0], 1'b0, 4'($urandom)};
         wr(AWC_IDX_RATE, d);
         rd_chk(AWC_IDX_RATE, d);
         chk_word({29'h0, sbr}, {29'h0, d[7:5]});
      end
      awc_host_inst.fast_seq(int'($urandom_range(2)));
      wr(AWC_IDX_RATE, 8'h0f);
      rd_chk(8'h29, 8'h00);
      chk_word({28'h0, smr}, 32'h0000000f);
      for (int s = 0; s < 8; s++)
      begin
         sh[s] = 6'($urandom);
         shd(3'(s), {2'b00, sh[s]});
      end
      for (int s = 0; s < 8; s++)
      begin
         wr(AWC_IDX_CFG, 8'(s));
         rd_chk(AWC_IDX_CFG, 8'(s));
         rd_chk(AWC_IDX_THR, (s % 4 == 0) ? 8'h00 : {2'b00, sh[s]});
      end
      for (int s = 1; s < 8; s++)
         shd(3'(s), (s < 4) ? 8'h0a : 8'h00);
      wr(AWC_IDX_IEN, 8'h01);
      wr(AWC_IDX_WCTL, 8'h0f);
      smp(0, 0, 0, 1'b0);
      smp(10, 0, 0, 1'b0);
      smp(21, 0, 0, 1'b1);
      smp(21, 0, 0, 1'b0);
      chk_bit(irq, 1'b1);
      rd_chk(AWC_IDX_STAT, 8'h03);
      wr(AWC_IDX_CLR, 8'h0f);
      rd_chk(AWC_IDX_STAT, 8'h00);
      chk_bit(irq, 1'b0);
      wr(AWC_IDX_IEN, 8'h00);
      smp(0, 0, 0, 1'b1);
      chk_bit(irq, 1'b0);
      wr(AWC_IDX_IEN, 8'h01);
      rd_chk(AWC_IDX_CLR, 8'h00);
      chk_bit(irq, 1'b1);
      wr(AWC_IDX_CLR, 8'h0f);
      wr(AWC_IDX_WCTL, 8'h00);
      shd(3'h1, 8'h8a);
      wr(AWC_IDX_WCTL, 8'h0f);
      smp(0, 0, 0, 1'b0);
      smp(21, 0, 0, 1'b1);
      smp(21, 0, 0, 1'b1);
      wr(AWC_IDX_WCTL, 8'h00);
      shd(3'h1, 8'h4a);
      wr(AWC_IDX_WCTL, 8'h0f);
      smp(0, 0, 0, 1'b0);
      smp(20, 20, 0, 1'b0);
      smp(40, 40, 20, 1'b1);
      wr(AWC_IDX_WCTL, 8'h07);
      smp(60, 60, 0, 1'b1);
      wr(AWC_IDX_WCTL, 8'h00);
      shd(3'h5, 8'h01);
      wr(AWC_IDX_WCTL, 8'h0f);
      smp(0, 0, 0, 1'b0);
      smp(20, 0, 0, 1'b0);
      smp(40, 0, 0, 1'b1);
      shd(3'h5, 8'h00);
      for (int s = 1; s < 4; s++)
         shd(3'(s), 8'h1e);
      wr(AWC_IDX_WCTL, 8'h00);
      wr(AWC_IDX_WCTL, 8'h0f);
      p = '{0, 0, 0};
      smp(0, 0, 0, 1'b0);
      repeat (20)
      begin
         e = 1'b0;
         foreach (c[k])
         begin
            c[k] = int'($urandom_range(80)) - 40;
            e = e | over(c[k], p[k], 30);
         end
         smp(c[0], c[1], c[2], e);
         p = c;
      end
      give_verdict();
   end
endmodule // awc_top_tb_top
